// File: design/meas_frame_pkg.sv
/*
 Shared constants for the measurement packet framer: byte layout, status
 bit positions, address offsets and frame state encoding.
 Assumes a single 10 MHz clock domain with synchronous active-high reset.
*/
package meas_frame_pkg;
    localparam logic [7:0] SYNC_BYTE      = 8'h00_A6;
    localparam logic [7:0] POLL_PREFIX    = 8'h00_A9;
    localparam logic [7:0] X_ADDR_OFFSET  = 8'h00_01;
    localparam logic [7:0] Y_ADDR_OFFSET  = 8'h00_02;
    localparam int         FRAME_BYTES    = 7;
    localparam int         READING_BITS   = 18;
    localparam int         STATUS_BITS    = 6;
    localparam int         SAT_BIT        = 0;
    localparam int         POL_BIT        = 1;
    localparam int         AVG_BIT        = 2;
    localparam int         MEMERR_BIT     = 4;
    localparam int         IDX_BITS       = 3;
    localparam logic [2:0] IDX_PREFIX     = 3'h0;
    localparam logic [2:0] IDX_ADDR       = 3'h1;
    localparam logic [2:0] IDX_STATUS     = 3'h2;
    localparam logic [2:0] IDX_MIDDLE     = 3'h3;
    localparam logic [2:0] IDX_UPPER      = 3'h4;
    localparam logic [2:0] IDX_AUX        = 3'h5;
    localparam logic [2:0] IDX_CSUM       = 3'h6;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_WAIT = 3'b100
    } frame_state_t;

    // Status bits 5..0 from flags; b3 is spare and b5 always zero
    function automatic logic [5:0] pack_status(
        input logic       sat,
        input logic       pol,
        input logic       avg,
        input logic       mem_err,
        input logic [1:0] mem_region
    );
        logic [5:0] s;
        s = 6'h00;
        s[SAT_BIT] = sat;
        s[MEMERR_BIT] = mem_err;
        if (mem_err)
        begin
            s[POL_BIT] = mem_region[0];
            s[AVG_BIT] = mem_region[1];
        end
        else
        begin
            s[POL_BIT] = pol;
            s[AVG_BIT] = avg;
        end
        return s;
    endfunction
endpackage

// File: design/sample_hold.sv
/*
 Holds the latest filter output and its sample count so a repeated poll can
 resend it. Assumes load pulses come from the measurement pipeline.
*/
`timescale 1ns/100ps
module sample_hold
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        load,
    input  wire logic        taken,
    input  wire logic [17:0] reading_in,
    input  wire logic [7:0]  count_in,
    input  wire logic        sat_in,
    output logic      [17:0] reading_out,
    output logic      [7:0]  count_out,
    output logic             sat_out,
    output logic             fresh_out
);
    typedef struct packed
    {
        logic [17:0] reading;
        logic [7:0]  count;
        logic        sat;
        logic        fresh;
    } hold_t;

    hold_t s_q;
    hold_t s_d;

    always_comb
    begin
        s_d = s_q;
        // New sample wins over a same-cycle consume
        if (taken)
            s_d.fresh = 1'b0;
        if (load)
        begin
            s_d.reading = reading_in;
            s_d.count   = count_in;
            s_d.sat     = sat_in;
            s_d.fresh   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            s_q <= '0;
        else if (clk_en)
            s_q <= s_d;
    end

    assign reading_out = s_q.reading;
    assign count_out   = s_q.count;
    assign sat_out     = s_q.sat;
    assign fresh_out   = s_q.fresh;
endmodule

// File: design/frame_checksum.sv
/*
 Running checksum over the bytes of one response. The scheme is an 8-bit
 sum, inverted at the end; the link's general scheme is assumed to match.
*/
`timescale 1ns/100ps
module frame_checksum
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       clear,
    input  wire logic       add,
    input  wire logic [7:0] byte_in,
    output logic      [7:0] csum_out
);
    typedef struct packed
    {
        logic [7:0] sum;
    } csum_t;

    csum_t s_q;
    csum_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (clear)
            s_d.sum = 8'h00;
        else if (add)
            s_d.sum = 8'(s_q.sum + byte_in);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            s_q <= '0;
        else if (clk_en)
            s_q <= s_d;
    end

    assign csum_out = ~s_q.sum;
endmodule

// File: design/measurement_packet_framer.sv
/*
 Builds the seven-byte measurement response for one or two sensor axes and
 streams it out byte by byte under a valid/ready handshake. Assumes the
 poll decoder upstream has checked prefix, address and checksum and gives
 a one-cycle poll pulse per axis request.
*/
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: Seven bytes: prefix, address, four content bytes, checksum.
// RULE2: Dual-axis poll sends X frame then Y frame, fourteen bytes total.
// RULE3: First byte is always sync value A6.
// RULE4: Address byte is base plus one for X, plus two for Y.
// RULE5: Content carries 18-bit reading, six status flags, one aux byte.
// RULE6: Content order is status, middle data, upper data, aux.
// RULE7: Reading left-justified; its two LSBs sit in status bits 7 and 6.
// RULE8: Bits 4,5 zero normally; bit 1 reverse polarity, bit 2 averaging.
// RULE9: Startup memory error sets bit 4; bits 1,2 show the failing region.
// RULE10: Bit 0 flags front-end saturation for this sample only.
// RULE11: With averaging, aux byte reports samples currently in the average.
// RULE12: Repeat poll before new output, non-continuous: aux zero, same data.
// RULE13: Aux byte always sent even when averaging is off.
// RULE14: Inclinometer reading is sign plus 17-bit magnitude in millidegrees.
// RULE15: Accelerometer reading is signed fraction, same packet layout.
// RULE16: Host keeping upper and middle bytes reads sign plus 15 bits.
// RULE17: Left-justified 32-bit: +60 deg 0x3A980000, -60 deg 0xBA980000.
// RULE18: Short poll with prefix A9 and address triggers one response.
// RULE19: Bytes go back to back; last byte is checksum of the others.
module measurement_packet_framer
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic [7:0]  base_addr,
    input  wire logic        poll_x,
    input  wire logic        poll_y,
    input  wire logic        x_load,
    input  wire logic [17:0] x_reading,
    input  wire logic [7:0]  x_count,
    input  wire logic        x_sat,
    input  wire logic        y_load,
    input  wire logic [17:0] y_reading,
    input  wire logic [7:0]  y_count,
    input  wire logic        y_sat,
    input  wire logic        reverse_polarity,
    input  wire logic        averaging_on,
    input  wire logic        continuous_avg,
    input  wire logic        mem_error,
    input  wire logic [1:0]  mem_region,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             tx_last,
    output logic             busy
);
    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed
    {
        meas_frame_pkg::frame_state_t state;
        logic [2:0]  idx;
        logic        y_pending;
        logic [7:0]  addr;
        logic [17:0] reading;
        logic [5:0]  status;
        logic [7:0]  aux;
        logic [7:0]  data;
    } framer_t;

    framer_t s_q;
    framer_t s_d;

    logic [17:0] hx_reading;
    logic [17:0] hy_reading;
    logic [7:0]  hx_count;
    logic [7:0]  hy_count;
    logic        hx_sat;
    logic        hy_sat;
    logic        hx_fresh;
    logic        hy_fresh;
    logic        take_x;
    logic        take_y;
    logic        start;
    logic        start_y;
    logic        beat;
    logic        csum_clear;
    logic [7:0]  csum;
    logic [7:0]  next_byte;
    logic [17:0] sel_reading;
    logic [7:0]  sel_count;
    logic        sel_sat;
    logic        sel_fresh;

    ////////////////////////////////////////////////////////////////////////////
    // Per-axis latest samples

    sample_hold u_hold_x
    (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .clk_en      (clk_en),
        .load        (x_load),
        .taken       (take_x),
        .reading_in  (x_reading),
        .count_in    (x_count),
        .sat_in      (x_sat),
        .reading_out (hx_reading),
        .count_out   (hx_count),
        .sat_out     (hx_sat),
        .fresh_out   (hx_fresh)
    );

    sample_hold u_hold_y
    (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .clk_en      (clk_en),
        .load        (y_load),
        .taken       (take_y),
        .reading_in  (y_reading),
        .count_in    (y_count),
        .sat_in      (y_sat),
        .reading_out (hy_reading),
        .count_out   (hy_count),
        .sat_out     (hy_sat),
        .fresh_out   (hy_fresh)
    );

    // Checksum covers the six bytes ahead of it
    frame_checksum u_csum
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .clear    (csum_clear),
        .add      (beat),
        .byte_in  (s_q.data),
        .csum_out (csum)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Handshake

    assign beat = clk_en && s_q.state == meas_frame_pkg::ST_SEND && tx_ready;
    // RULE18: poll launches frame
    assign start = clk_en && s_q.state == meas_frame_pkg::ST_IDLE
                   && (poll_x || poll_y);
    // RULE2: Y frame follows X
    assign start_y = beat && s_q.idx == meas_frame_pkg::IDX_CSUM
                     && s_q.y_pending;
    assign take_x = start && poll_x;
    assign take_y = (start && !poll_x && poll_y) || start_y;
    assign csum_clear = start || start_y;

    ////////////////////////////////////////////////////////////////////////////
    // Byte selection

    // Checksum register lags one byte; fold the aux byte in here
    function automatic logic [7:0] next_sum_fix(input logic [7:0] b);
        return b;
    endfunction

    // RULE7: reading LSBs over flags
    function automatic logic [7:0] status_byte(
        input logic [17:0] reading,
        input logic [5:0]  status
    );
        return {reading[1:0], status};
    endfunction

    always_comb
    begin
        next_byte = 8'h00;
        case (s_q.idx)
            // RULE6: status byte first
            meas_frame_pkg::IDX_ADDR:
                next_byte = status_byte(s_q.reading, s_q.status);
            meas_frame_pkg::IDX_STATUS:
                next_byte = s_q.reading[9:2];
            // RULE17: upper byte holds MSBs
            meas_frame_pkg::IDX_MIDDLE:
                next_byte = s_q.reading[17:10];
            meas_frame_pkg::IDX_UPPER:
                next_byte = s_q.aux;
            // RULE19: checksum closes frame
            meas_frame_pkg::IDX_AUX:
                next_byte = 8'(csum - next_sum_fix(s_q.data));
            default:
                next_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Axis selection for the frame about to start

    // RULE4: base plus offset
    function automatic logic [7:0] axis_addr(
        input logic [7:0] base,
        input logic       y_axis
    );
        if (y_axis)
            return 8'(base + meas_frame_pkg::Y_ADDR_OFFSET);
        return 8'(base + meas_frame_pkg::X_ADDR_OFFSET);
    endfunction

    // RULE5: reading, flags, count
    // Y is snapped at its own start, so a late Y sample still counts
    always_comb
    begin
        sel_reading = hx_reading;
        sel_count   = hx_count;
        sel_sat     = hx_sat;
        sel_fresh   = hx_fresh;
        if (take_y)
        begin
            sel_reading = hy_reading;
            sel_count   = hy_count;
            sel_sat     = hy_sat;
            sel_fresh   = hy_fresh;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame loading: RULE9, RULE10, RULE11, RULE12, RULE13

    function automatic logic [7:0] pick_aux(
        input logic       avg,
        input logic       cont,
        input logic       fresh,
        input logic [7:0] count
    );
        // RULE12: stale repeat gives zero
        if (avg && !cont && !fresh)
            return 8'h00;
        // RULE11: sample count
        // RULE13: still sent when off
        return count;
    endfunction

    always_comb
    begin
        s_d = s_q;
        if (start || start_y)
        begin
            s_d.state  = meas_frame_pkg::ST_SEND;
            s_d.idx    = meas_frame_pkg::IDX_PREFIX;
            // RULE3: sync byte
            s_d.data   = meas_frame_pkg::SYNC_BYTE;
            // RULE2: X then Y
            s_d.y_pending = start && poll_x && poll_y;
            // RULE4: axis address
            s_d.addr   = axis_addr(base_addr, take_y);
            // RULE14: RULE15: reading passed through unchanged
            s_d.reading = sel_reading;
            // RULE8: RULE9: RULE10: status flags
            s_d.status  = meas_frame_pkg::pack_status(
                              sel_sat,
                              reverse_polarity, averaging_on,
                              mem_error, mem_region);
            s_d.aux     = pick_aux(averaging_on, continuous_avg,
                                   sel_fresh, sel_count);
        end
        else if (beat)
        begin
            // RULE1: seven bytes, then stop
            if (s_q.idx == meas_frame_pkg::IDX_CSUM)
            begin
                s_d.state = meas_frame_pkg::ST_IDLE;
                s_d.idx   = meas_frame_pkg::IDX_PREFIX;
            end
            else
            begin
                s_d.idx  = 3'(s_q.idx + 3'h1);
                s_d.data = (s_q.idx == meas_frame_pkg::IDX_PREFIX)
                           ? s_q.addr : next_byte;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_q       <= '0;
            s_q.state <= meas_frame_pkg::ST_IDLE;
        end
        else if (clk_en)
        begin
            // Low enable freezes a frame mid-byte
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; bytes stream back to back while ready is high

    assign tx_data  = s_q.data;
    // RULE1: valid while sending
    assign tx_valid = s_q.state == meas_frame_pkg::ST_SEND;
    // RULE2: last after final axis
    assign tx_last  = tx_valid && s_q.idx == meas_frame_pkg::IDX_CSUM
                      && !s_q.y_pending;
    assign busy     = s_q.state != meas_frame_pkg::ST_IDLE;
endmodule

// File: dv/framer_checker_assertions.sv
/*
 Concurrent checks on the measurement packet framer ports.
 Assumes one clock, synchronous active-high reset, bound to the top.
*/
`timescale 1ns/100ps
module framer_checker
(
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic [7:0] base_addr,
    input wire logic       poll_x,
    input wire logic       poll_y,
    input wire logic       mem_error,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       tx_last,
    input wire logic       busy
);
    logic [2:0] idx_q;
    logic [7:0] sum_q;
    logic       take;
    assign take = tx_valid && tx_ready && clk_en;
    // Byte position and running sum inside the current frame
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            idx_q <= 3'h0;
            sum_q <= 8'h00;
        end
        else if (take)
        begin
            idx_q <= (idx_q == 3'h6) ? 3'h0 : idx_q + 3'h1;
            sum_q <= (idx_q == 3'h6) ? 8'h00 : sum_q + tx_data;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_poll_answer: assert property ((poll_x || poll_y) && clk_en
        && !busy |=> tx_valid && tx_data == meas_frame_pkg::SYNC_BYTE)
        else $error("no sync byte after poll");
    a_stall_hold: assert property (tx_valid && !take
        |=> tx_valid && $stable(tx_data)) else $error("byte changed in stall");
    a_sync_first: assert property (tx_valid && idx_q == 3'h0
        |-> tx_data == meas_frame_pkg::SYNC_BYTE) else $error("bad prefix");
    a_addr_byte: assert property (tx_valid && idx_q == 3'h1
        |-> tx_data == base_addr + meas_frame_pkg::X_ADDR_OFFSET
        || tx_data == base_addr + meas_frame_pkg::Y_ADDR_OFFSET)
        else $error("bad address byte");
    a_status_spare: assert property (tx_valid && idx_q == 3'h2
        |-> !tx_data[5] && !tx_data[3] && tx_data[4] == mem_error)
        else $error("bad status byte");
    a_csum_byte: assert property (tx_valid && idx_q == 3'h6
        |-> tx_data == ~sum_q) else $error("bad checksum");
    a_last_place: assert property (tx_last
        |-> tx_valid && idx_q == 3'h6) else $error("last flag off frame end");
    a_back_to_back: assert property (take && idx_q != 3'h6
        |=> tx_valid) else $error("gap inside frame");
    a_busy_cover: assert property (tx_valid |-> busy)
        else $error("valid without busy");
    c_stall: cover property (tx_valid && !tx_ready);
    c_dual: cover property (poll_x && poll_y);
    c_last: cover property (tx_last && take);
    c_freeze: cover property (tx_valid && !clk_en);
endmodule
bind measurement_packet_framer framer_checker framer_checker_inst
(
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .base_addr(base_addr), .poll_x(poll_x), .poll_y(poll_y),
    .mem_error(mem_error), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_last(tx_last), .busy(busy)
);

// File: dv/host_model.sv
/*
 Polling host: takes response bytes, prompt or stalling two of three cycles.
 Assumes the bench reads the byte queue hierarchically.
*/
`timescale 1ns/100ps
module host_model
(
    input  wire logic       sys_clk,
    input  wire logic       clk_en,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    input  wire logic       slow,
    output logic            tx_ready
);
    logic [8:0] got[$];
    logic [1:0] ph_q = 2'h0;
    // Ready one cycle in three when slow
    assign tx_ready = !slow || ph_q == 2'h2;
    always @(posedge sys_clk)
    begin
        // Frozen cycles move no byte
        if (tx_valid && tx_ready && clk_en)
            got.push_back({tx_last, tx_data});
        ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    end
endmodule

// File: dv/tb_measurement_packet_framer.sv
/*
 Self-checking bench for the measurement packet framer.
 Assumes host_model and the checker are compiled alongside.
*/
`timescale 1ns/100ps
module tb_measurement_packet_framer;
    logic sys_clk = 0, reset = 1, clk_en = 1, slow = 0;
    logic [7:0] base_addr = 8'h00_70, tx_data, x_count = 0, y_count = 0;
    logic poll_x = 0, poll_y = 0, x_load = 0, y_load = 0, x_sat = 0;
    logic y_sat = 0, reverse_polarity = 0, averaging_on = 1;
    logic continuous_avg = 0, mem_error = 0, tx_valid, tx_ready, tx_last;
    logic busy;
    logic [1:0] mem_region = 0;
    logic [17:0] x_reading = 0, y_reading = 0;
    int err_count = 0, num_checks = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    measurement_packet_framer measurement_packet_framer_inst (.sys_clk,
        .reset, .clk_en, .base_addr, .poll_x, .poll_y, .x_load, .x_reading,
        .x_count, .x_sat, .y_load, .y_reading, .y_count, .y_sat,
        .reverse_polarity, .averaging_on, .continuous_avg, .mem_error,
        .mem_region, .tx_data, .tx_valid, .tx_ready, .tx_last, .busy);
    host_model host_model_inst (.sys_clk, .clk_en, .tx_data, .tx_valid,
        .tx_last, .slow, .tx_ready);
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    task check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task load(input logic [17:0] r, input logic [7:0] c, input logic s);
        {x_load, y_load, x_reading, y_reading} = {2'b11, r, r + 18'h0_0001};
        {x_count, y_count, x_sat, y_sat} = {c, c + 8'h01, s, s};
        tick();
        {x_load, y_load} = 2'b00;
    endtask
    task poll(input logic px, input logic py, input int n);
        host_model_inst.got.delete();
        {poll_x, poll_y} = {px, py};
        tick();
        {poll_x, poll_y} = 2'b00;
        for (int i = 0; i < 200 && host_model_inst.got.size() < n; i++)
            tick();
        repeat (4) tick();
        check(host_model_inst.got.size(), n);
    endtask
    task frame(input int k, input int ax, input logic [17:0] r,
               input logic s, input logic [7:0] aux, input logic last,
               input logic full);
        logic [7:0] e[7];
        logic [5:0] st;
        logic [8:0] g;
        st = {1'b0, mem_error, 1'b0,
              mem_error ? mem_region : {averaging_on, reverse_polarity}, s};
        e = '{meas_frame_pkg::SYNC_BYTE, base_addr + 8'(ax + 1),
              {r[1:0], st}, r[9:2], r[17:10], aux, 8'h00};
        // Aux undefined with averaging off; checksum still covers it
        if (!full)
            e[5] = host_model_inst.got[k * 7 + 5][7:0];
        for (int i = 0; i < 6; i++)
            e[6] = e[6] + e[i];
        e[6] = ~e[6];
        for (int i = 0; i < 7; i++)
        begin
            g = host_model_inst.got[k * 7 + i];
            if (full || i != 5)
                check(g, {i == 6 && last, e[i]});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Plus sixty degrees, then a repeat poll with no new sample
    task s_basic;
        load(18'h0_EA60, 8'h10, 1'b0);
        poll(1, 0, 7);
        frame(0, 0, 18'h0_EA60, 0, 8'h10, 1, 1);
        check({host_model_inst.got[4][7:0], host_model_inst.got[3][7:0],
               host_model_inst.got[2][7:6], 6'h00}, 24'h3A_9800);
        check({host_model_inst.got[4][7:0], host_model_inst.got[3][7:0]},
              16'h3A98);
        poll(1, 0, 7);
        frame(0, 0, 18'h0_EA60, 0, 8'h00, 1, 1);
    endtask
    // Both axes, negative reading, saturation, stalling host
    task s_dual;
        slow = 1;
        load(18'h2_EA61, 8'h07, 1'b1);
        poll(1, 1, 14);
        frame(0, 0, 18'h2_EA61, 1, 8'h07, 0, 1);
        frame(1, 1, 18'h2_EA62, 1, 8'h08, 1, 1);
        slow = 0;
    endtask
    // Continuous mode keeps the count; polarity flag
    task s_cont;
        {continuous_avg, reverse_polarity} = 2'b11;
        load(18'h1_5553, 8'h20, 1'b0);
        poll(0, 1, 7);
        poll(0, 1, 7);
        frame(0, 1, 18'h1_5554, 0, 8'h21, 1, 1);
        check(host_model_inst.got[1], {1'b0, base_addr + 8'h02});
        check(host_model_inst.got[5], {1'b0, 8'h21});
        {continuous_avg, reverse_polarity} = 2'b00;
    endtask
    // Memory error region, averaging off keeps length
    task s_memerr;
        {mem_error, mem_region, averaging_on} = 4'b1100;
        load(18'h3_FFFF, 8'h05, 1'b0);
        poll(1, 0, 7);
        frame(0, 0, 18'h3_FFFF, 0, 8'h00, 1, 0);
        {mem_error, mem_region, averaging_on} = 4'b0001;
    endtask
    // Enable low mid-frame freezes it; a poll while busy is dropped
    task s_freeze;
        load(18'h0_1234, 8'h03, 1'b0);
        host_model_inst.got.delete();
        poll_x = 1;
        tick();
        {poll_x, poll_y} = 2'b01;
        tick();
        poll_y = 0;
        clk_en = 0;
        repeat (5) tick();
        check(host_model_inst.got.size(), 1);
        check({tx_valid, busy}, 2'b11);
        clk_en = 1;
        repeat (30) tick();
        check(host_model_inst.got.size(), 7);
        frame(0, 0, 18'h0_1234, 0, 8'h03, 1, 1);
    endtask
    initial
    begin
        repeat (12) tick();
        reset = 0;
        s_basic();
        s_dual();
        s_cont();
        s_memerr();
        s_freeze();
        report_and_stop();
    end
endmodule
